// ==== dbp_defines.svh ====
`ifndef DBP_DEFINES_SVH
`define DBP_DEFINES_SVH
// Register byte offsets on the APB slave
`define DBP_OFF_CTRL 8'h00
`define DBP_OFF_ENGAGE 8'h04
`define DBP_OFF_DISENG 8'h08
`define DBP_OFF_HEATLIM 8'h0c
`define DBP_OFF_COOL 8'h10
`define DBP_OFF_OVLIM 8'h14
`define DBP_OFF_UVLIM 8'h18
`define DBP_OFF_DECV 8'h1c
`define DBP_OFF_ACCI 8'h20
`define DBP_OFF_DECRATE 8'h24
`define DBP_OFF_ACCRATE 8'h28
`define DBP_OFF_PMAX 8'h2c
`define DBP_OFF_PMIN 8'h30
`define DBP_OFF_KP 8'h34
`define DBP_OFF_KI 8'h38
`define DBP_OFF_STATUS 8'h3c
`define DBP_OFF_HEAT 8'h40
`define DBP_OFF_DECNOW 8'h44
`define DBP_OFF_ACCNOW 8'h48
`define DBP_OFF_ACCPWR 8'h4c
`define DBP_OFF_DECPWR 8'h50
`define DBP_OFF_PCMD 8'h54
`define DBP_OFF_PTGT 8'h58
// Control and status field positions
`define DBP_CTRL_BRAKE_EN 0
`define DBP_CTRL_SELECT 1
`define DBP_CTRL_RUN 2
`define DBP_ST_OV 0
`define DBP_ST_UV 1
`define DBP_ST_BRAKE 2
`define DBP_ST_FORCED 3
`define DBP_ST_LOOP 4
// Reset values
`define DBP_RST_CTRL 3'h1
`define DBP_RST_ENGAGE 16'h9470
`define DBP_RST_DISENG 16'h9088
`define DBP_RST_HEATLIM 16'hea60
`define DBP_RST_COOL 16'hd6d8
`define DBP_RST_OVLIM 16'h9c40
`define DBP_RST_UVLIM 16'h2710
`define DBP_RST_DECV 16'h88b8
`define DBP_RST_ACCI 16'h1388
`define DBP_RST_RATE 16'h03e8
`define DBP_RST_PLIM 16'h0000
`define DBP_RST_KP 32'h00080000
`define DBP_RST_KI 32'h000003e8
// Timing and scaling
`define DBP_CLK_NS 40
`define DBP_TICK_NS 1000000
`define DBP_TICK_CYC (`DBP_TICK_NS / `DBP_CLK_NS)
`define DBP_SLEW_STEP 16'h000f
`define DBP_RATE_FLOOR 16'h000f
`define DBP_THR_SPAN 16'hfa00
`define DBP_THR_RECIP 11'h419
`define DBP_THR_SHIFT 26
`define DBP_WIN_MS 10'h3e8
`define DBP_PWR_RATE_MAX 16'h0032
`endif

// ==== dbp_pkg.sv ====
package dbp_pkg;
   // Braking resistor controller states
   typedef enum logic [1:0] {
      dbp_brk_off,
      dbp_brk_on,
      dbp_brk_cool
   } dbp_brake_t;
endpackage

// ==== dbp_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbp_defines.svh"
module dbp_tick #(
   parameter int CYCLES = `DBP_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   output logic tick
);
   logic [15:0] count; // Cycles since last tick

   // Free running divider, one-cycle pulse at wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (clk_en) begin
         if (count == 16'(CYCLES - 1)) begin
            count <= 16'h0000;
            tick <= 1'b1;
         end else begin
            count <= count + 16'h0001;
            tick <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== dbp_pi.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbp_pi (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic step,
   input wire logic active,
   input wire logic signed [31:0] kp,
   input wire logic signed [31:0] ki,
   input wire logic signed [31:0] err,
   output logic signed [31:0] out
);
   logic signed [31:0] integ; // Sum of past errors
   logic signed [32:0] next_sum; // Wide sum for saturation
   logic signed [63:0] p_term; // Kp times error
   logic signed [63:0] i_term; // Ki times sum
   logic signed [63:0] total; // Sum in 16.16 scale

   assign next_sum = 33'(integ) + 33'(err);
   assign p_term = 64'(kp) * 64'(err);
   assign i_term = 64'(ki) * 64'(integ);
   assign total = p_term + i_term;

   // Integrator saturates rather than wraps, avoiding a sign flip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integ <= 32'h00000000;
      end else if (clk_en) begin
         if (!active) begin
            integ <= 32'h00000000;
         end else if (step) begin
            if (next_sum[32] != next_sum[31]) begin
               integ <= next_sum[32] ? 32'h80000000 : 32'h7fffffff;
            end else begin
               integ <= next_sum[31:0];
            end
         end
      end
   end

   // Drop the 16 fraction bits, 65536 is unity gain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out <= 32'h00000000;
      end else if (clk_en && step) begin
         out <= total[47:16];
      end
   end
endmodule
`default_nettype wire

// ==== dbp_top.sv ====
// Behaviour
// - Brake works only when brake enable set
// - Resistor on at engage threshold voltage
// - Resistor off at disengage threshold voltage
// - Heat counter up when on, down off
// - Heat limit reached forces resistor off
// - Forced off until heat drops to cooldown
// - Bus above overvoltage limit trips shutdown
// - Bus below undervoltage limit trips shutdown
// - Decel rate cut with voltage excess
// - Cut reaches 15 rpm/s at 64 V
// - Decel rate regains 15 rpm per tick
// - Accel rate cut with current excess
// - Accel rate regains 15 rpm per tick
// - Running power never above upper limit
// - Running power never below lower limit
// - Gains are signed 16.16 fixed point
// - Proportional term is gain times error
// - Integral term is gain times error sum
// - Accel and decel power are read only
// - Power loop runs only when selected
`timescale 1ns/1ns
`default_nettype none
`include "dbp_defines.svh"
module dbp_top
   import dbp_pkg::*;
#(
   parameter int TICK_CYCLES = `DBP_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] bus_voltage_mv,
   input wire logic [15:0] motor_current_ma,
   input wire logic [15:0] measured_power_w,
   output logic brake_resistor_on,
   output logic drive_shutdown,
   output logic overvoltage_fault,
   output logic undervoltage_fault,
   output logic [15:0] decel_rate_now,
   output logic [15:0] accel_rate_now,
   output logic [15:0] power_command,
   output logic power_loop_active
);
   // Software settings
   logic [2:0] ctrl; // Enable, select, run
   logic [15:0] brake_engage_threshold;
   logic [15:0] brake_disengage_threshold;
   logic [15:0] brake_heat_limit;
   logic [15:0] brake_cooldown_level;
   logic [15:0] bus_overvoltage_limit;
   logic [15:0] bus_undervoltage_limit;
   logic [15:0] decel_throttle_voltage;
   logic [15:0] accel_throttle_current;
   logic [15:0] decel_rate_cfg; // Configured decel rpm/s
   logic [15:0] accel_rate_cfg; // Configured accel rpm/s
   logic [15:0] power_upper_limit;
   logic [15:0] power_lower_limit;
   logic [31:0] power_proportional_gain;
   logic [31:0] power_integral_gain;
   logic [15:0] power_target; // Power setpoint in watts
   // Block state
   logic tick; // One-cycle millisecond pulse
   dbp_brake_t state; // Brake controller state
   dbp_brake_t next_state;
   logic [15:0] heat; // Accumulated on-time in ms
   logic [15:0] accel_power_value; // Watts per second rising
   logic [15:0] decel_power_value; // Watts per second falling
   logic [15:0] snap_power; // Power at window start
   logic [9:0] win_count; // Ticks into rate window
   logic signed [31:0] pi_out; // Raw controller output
   // Bus decode
   logic [31:0] rd_mux;
   logic mapped;
   logic wr_en;
   logic running;
   logic brake_enable;
   logic control_variable_select;
   logic ov_now;
   logic uv_now;
   logic [15:0] dec_target;
   logic [15:0] acc_target;
   logic signed [31:0] pwr_err;
   logic signed [16:0] pwr_delta;

   assign brake_enable = ctrl[`DBP_CTRL_BRAKE_EN];
   assign control_variable_select = ctrl[`DBP_CTRL_SELECT];
   assign running = ctrl[`DBP_CTRL_RUN] & ~drive_shutdown;

   // Linear cut: full rate at zero excess, floor at full span
   function automatic logic [15:0] dbp_throttle(
      input logic [15:0] cfg,
      input logic [15:0] excess
   );
      logic [42:0] prod;
      logic [15:0] cut;
      prod = 43'(cfg - `DBP_RATE_FLOOR) * 43'(excess) * 43'(`DBP_THR_RECIP);
      cut = 16'(prod >> `DBP_THR_SHIFT);
      if (cfg <= `DBP_RATE_FLOOR) begin
         dbp_throttle = cfg;
      end else if (excess >= `DBP_THR_SPAN) begin
         dbp_throttle = `DBP_RATE_FLOOR;
      end else begin
         dbp_throttle = (cut >= cfg - `DBP_RATE_FLOOR) ? `DBP_RATE_FLOOR : cfg - cut;
      end
   endfunction

   // Millisecond pacing divider
   dbp_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .tick(tick)
   );

   // Zero wait states; a frozen clock holds the transfer off
   assign pready = clk_en;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = psel & penable & pwrite & clk_en & mapped;

   // Read mux and address map
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      unique case (paddr)
         `DBP_OFF_CTRL: rd_mux = {29'h0, ctrl};
         `DBP_OFF_ENGAGE: rd_mux = {16'h0, brake_engage_threshold};
         `DBP_OFF_DISENG: rd_mux = {16'h0, brake_disengage_threshold};
         `DBP_OFF_HEATLIM: rd_mux = {16'h0, brake_heat_limit};
         `DBP_OFF_COOL: rd_mux = {16'h0, brake_cooldown_level};
         `DBP_OFF_OVLIM: rd_mux = {16'h0, bus_overvoltage_limit};
         `DBP_OFF_UVLIM: rd_mux = {16'h0, bus_undervoltage_limit};
         `DBP_OFF_DECV: rd_mux = {16'h0, decel_throttle_voltage};
         `DBP_OFF_ACCI: rd_mux = {16'h0, accel_throttle_current};
         `DBP_OFF_DECRATE: rd_mux = {16'h0, decel_rate_cfg};
         `DBP_OFF_ACCRATE: rd_mux = {16'h0, accel_rate_cfg};
         `DBP_OFF_PMAX: rd_mux = {16'h0, power_upper_limit};
         `DBP_OFF_PMIN: rd_mux = {16'h0, power_lower_limit};
         `DBP_OFF_KP: rd_mux = power_proportional_gain;
         `DBP_OFF_KI: rd_mux = power_integral_gain;
         `DBP_OFF_STATUS: rd_mux = {27'h0, power_loop_active,
            state == dbp_brk_cool, brake_resistor_on,
            undervoltage_fault, overvoltage_fault};
         `DBP_OFF_HEAT: rd_mux = {16'h0, heat};
         `DBP_OFF_DECNOW: rd_mux = {16'h0, decel_rate_now};
         `DBP_OFF_ACCNOW: rd_mux = {16'h0, accel_rate_now};
         `DBP_OFF_ACCPWR: rd_mux = {16'h0, accel_power_value};
         `DBP_OFF_DECPWR: rd_mux = {16'h0, decel_power_value};
         `DBP_OFF_PCMD: rd_mux = {16'h0, power_command};
         `DBP_OFF_PTGT: rd_mux = {16'h0, power_target};
         default: mapped = 1'b0;
      endcase
   end

   // Read data captured in setup, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Settings registers; read-only words ignore writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `DBP_RST_CTRL;
         brake_engage_threshold <= `DBP_RST_ENGAGE;
         brake_disengage_threshold <= `DBP_RST_DISENG;
         brake_heat_limit <= `DBP_RST_HEATLIM;
         brake_cooldown_level <= `DBP_RST_COOL;
         bus_overvoltage_limit <= `DBP_RST_OVLIM;
         bus_undervoltage_limit <= `DBP_RST_UVLIM;
         decel_throttle_voltage <= `DBP_RST_DECV;
         accel_throttle_current <= `DBP_RST_ACCI;
         decel_rate_cfg <= `DBP_RST_RATE;
         accel_rate_cfg <= `DBP_RST_RATE;
         power_upper_limit <= `DBP_RST_PLIM;
         power_lower_limit <= `DBP_RST_PLIM;
         power_proportional_gain <= `DBP_RST_KP;
         power_integral_gain <= `DBP_RST_KI;
         power_target <= 16'h0000;
      end else if (wr_en) begin
         unique case (paddr)
            `DBP_OFF_CTRL: ctrl <= pwdata[2:0];
            `DBP_OFF_ENGAGE: brake_engage_threshold <= pwdata[15:0];
            `DBP_OFF_DISENG: brake_disengage_threshold <= pwdata[15:0];
            `DBP_OFF_HEATLIM: brake_heat_limit <= pwdata[15:0];
            `DBP_OFF_COOL: brake_cooldown_level <= pwdata[15:0];
            `DBP_OFF_OVLIM: bus_overvoltage_limit <= pwdata[15:0];
            `DBP_OFF_UVLIM: bus_undervoltage_limit <= pwdata[15:0];
            `DBP_OFF_DECV: decel_throttle_voltage <= pwdata[15:0];
            `DBP_OFF_ACCI: accel_throttle_current <= pwdata[15:0];
            `DBP_OFF_DECRATE: decel_rate_cfg <= pwdata[15:0];
            `DBP_OFF_ACCRATE: accel_rate_cfg <= pwdata[15:0];
            `DBP_OFF_PMAX: power_upper_limit <= pwdata[15:0];
            `DBP_OFF_PMIN: power_lower_limit <= pwdata[15:0];
            `DBP_OFF_KP: power_proportional_gain <= pwdata;
            `DBP_OFF_KI: power_integral_gain <= pwdata;
            `DBP_OFF_PTGT: power_target <= pwdata[15:0];
            default: ; // Status and measured words
         endcase
      end
   end

   // Bus limit comparators, checked every cycle
   assign ov_now = bus_voltage_mv > bus_overvoltage_limit;
   assign uv_now = bus_voltage_mv < bus_undervoltage_limit;

   // Sticky faults; a new trip beats a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overvoltage_fault <= 1'b0;
         undervoltage_fault <= 1'b0;
      end else if (clk_en) begin
         overvoltage_fault <= ov_now | (overvoltage_fault &
            ~(wr_en && paddr == `DBP_OFF_STATUS && pwdata[`DBP_ST_OV]));
         undervoltage_fault <= uv_now | (undervoltage_fault &
            ~(wr_en && paddr == `DBP_OFF_STATUS && pwdata[`DBP_ST_UV]));
      end
   end

   // Shutdown follows the trip one edge later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_shutdown <= 1'b0;
      end else if (clk_en) begin
         drive_shutdown <= ov_now | uv_now | overvoltage_fault |
            undervoltage_fault;
      end
   end

   // Hysteretic brake decision, applied on each tick
   always_comb begin
      next_state = state;
      unique case (state)
         dbp_brk_off: begin
            if (brake_enable && heat < brake_heat_limit &&
                bus_voltage_mv >= brake_engage_threshold) begin
               next_state = dbp_brk_on;
            end
         end
         dbp_brk_on: begin
            if (!brake_enable) begin
               next_state = dbp_brk_off;
            end else if (heat >= brake_heat_limit) begin
               next_state = dbp_brk_cool;
            end else if (bus_voltage_mv <= brake_disengage_threshold) begin
               next_state = dbp_brk_off;
            end
         end
         dbp_brk_cool: begin
            // Lockout ignores the bus until cooled down
            if (heat <= brake_cooldown_level) begin
               next_state = dbp_brk_off;
            end
         end
      endcase
   end

   // Brake state and resistor drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= dbp_brk_off;
         brake_resistor_on <= 1'b0;
      end else if (clk_en) begin
         if (!brake_enable) begin
            state <= (state == dbp_brk_on) ? dbp_brk_off : state;
            brake_resistor_on <= 1'b0;
         end else if (tick) begin
            state <= next_state;
            brake_resistor_on <= next_state == dbp_brk_on;
         end
      end
   end

   // Heat counter, saturating at both ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         heat <= 16'h0000;
      end else if (clk_en && tick) begin
         if (brake_resistor_on && heat != 16'hffff) begin
            heat <= heat + 16'h0001;
         end else if (!brake_resistor_on && heat != 16'h0000) begin
            heat <= heat - 16'h0001;
         end
      end
   end

   // Throttle targets from the size of the excess
   assign dec_target = dbp_throttle(decel_rate_cfg,
      bus_voltage_mv - decel_throttle_voltage);
   assign acc_target = dbp_throttle(accel_rate_cfg,
      motor_current_ma - accel_throttle_current);

   // Decel rate: cut at once, regain slowly to avoid bounce
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decel_rate_now <= `DBP_RST_RATE;
      end else if (clk_en && tick) begin
         if (bus_voltage_mv > decel_throttle_voltage) begin
            if (dec_target < decel_rate_now) begin
               decel_rate_now <= dec_target;
            end
         end else if (bus_voltage_mv < decel_throttle_voltage) begin
            if (decel_rate_now >= decel_rate_cfg - `DBP_SLEW_STEP ||
                decel_rate_cfg < `DBP_SLEW_STEP) begin
               decel_rate_now <= decel_rate_cfg;
            end else begin
               decel_rate_now <= decel_rate_now + `DBP_SLEW_STEP;
            end
         end
      end
   end

   // Accel rate: same shape, driven by motor current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accel_rate_now <= `DBP_RST_RATE;
      end else if (clk_en && tick) begin
         if (motor_current_ma > accel_throttle_current) begin
            if (acc_target < accel_rate_now) begin
               accel_rate_now <= acc_target;
            end
         end else if (motor_current_ma < accel_throttle_current) begin
            if (accel_rate_now >= accel_rate_cfg - `DBP_SLEW_STEP ||
                accel_rate_cfg < `DBP_SLEW_STEP) begin
               accel_rate_now <= accel_rate_cfg;
            end else begin
               accel_rate_now <= accel_rate_now + `DBP_SLEW_STEP;
            end
         end
      end
   end

   // Power loop only in power mode while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_loop_active <= 1'b0;
      end else if (clk_en) begin
         power_loop_active <= running & control_variable_select;
      end
   end

   assign pwr_err = 32'(signed'({16'h0, power_target})) -
      32'(signed'({16'h0, measured_power_w}));

   // Power controller core
   dbp_pi u_pi (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .step(tick),
      .active(power_loop_active),
      .kp(signed'(power_proportional_gain)),
      .ki(signed'(power_integral_gain)),
      .err(pwr_err),
      .out(pi_out)
   );

   // Command clamp; a stopped drive commands zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_command <= 16'h0000;
      end else if (clk_en) begin
         if (!running) begin
            power_command <= 16'h0000;
         end else if (!control_variable_select) begin
            // Speed mode: setpoint passes, still bounded
            if (power_target > power_upper_limit) begin
               power_command <= power_upper_limit;
            end else if (power_target < power_lower_limit) begin
               power_command <= power_lower_limit;
            end else begin
               power_command <= power_target;
            end
         end else if (pi_out > 32'(signed'({16'h0, power_upper_limit}))) begin
            power_command <= power_upper_limit;
         end else if (pi_out < 32'(signed'({16'h0, power_lower_limit}))) begin
            power_command <= power_lower_limit;
         end else begin
            power_command <= pi_out[15:0];
         end
      end
   end

   assign pwr_delta = 17'({1'b0, measured_power_w}) - 17'({1'b0, snap_power});

   // Power change over a one-second window, read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_count <= 10'h000;
         snap_power <= 16'h0000;
         accel_power_value <= 16'h0000;
         decel_power_value <= 16'h0000;
      end else if (clk_en && tick) begin
         if (win_count == `DBP_WIN_MS - 10'h001) begin
            win_count <= 10'h000;
            snap_power <= measured_power_w;
            if (!pwr_delta[16]) begin
               accel_power_value <= (pwr_delta[15:0] > `DBP_PWR_RATE_MAX) ?
                  `DBP_PWR_RATE_MAX : pwr_delta[15:0];
               decel_power_value <= 16'h0000;
            end else begin
               accel_power_value <= 16'h0000;
               decel_power_value <= (16'(-pwr_delta) > `DBP_PWR_RATE_MAX) ?
                  `DBP_PWR_RATE_MAX : 16'(-pwr_delta);
            end
         end else begin
            win_count <= win_count + 10'h001;
         end
      end
   end
endmodule
`default_nettype wire

// ==== dbp_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbp_defines.svh"
module dbp_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [15:0] bus_voltage_mv,
   input wire logic brake_resistor_on,
   input wire logic drive_shutdown,
   input wire logic overvoltage_fault,
   input wire logic undervoltage_fault,
   input wire logic [15:0] decel_rate_now
);
   logic en; // Brake enable as last written
   logic [15:0] eng, ovl, uvl; // Engage and trip limits
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Limits live in registers, so mirror the writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en <= 1'b1;
         eng <= `DBP_RST_ENGAGE;
         ovl <= `DBP_RST_OVLIM;
         uvl <= `DBP_RST_UVLIM;
      end else if (psel && penable && pwrite && clk_en) begin
         case (paddr)
            `DBP_OFF_CTRL: en <= pwdata[`DBP_CTRL_BRAKE_EN];
            `DBP_OFF_ENGAGE: eng <= pwdata[15:0];
            `DBP_OFF_OVLIM: ovl <= pwdata[15:0];
            `DBP_OFF_UVLIM: uvl <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   property p_ov; clk_en && bus_voltage_mv > ovl |=> overvoltage_fault; endproperty
   a_ov: assert property (p_ov) else $error("overvoltage missed");
   property p_uv; clk_en && bus_voltage_mv < uvl |=> undervoltage_fault; endproperty
   a_uv: assert property (p_uv) else $error("undervoltage missed");
   property p_shut; overvoltage_fault || undervoltage_fault |-> drive_shutdown; endproperty
   a_shut: assert property (p_shut) else $error("fault without shutdown");
   property p_dis; !en |=> !brake_resistor_on; endproperty
   a_dis: assert property (p_dis) else $error("brake on while disabled");
   property p_on; $rose(brake_resistor_on) |-> $past(bus_voltage_mv) >= $past(eng); endproperty
   a_on: assert property (p_on) else $error("brake on below engage");
   property p_hold; $rose(brake_resistor_on) |=> ($stable(brake_resistor_on) || !en) [*8]; endproperty
   a_hold: assert property (p_hold) else $error("brake moved between ticks");
   property p_slew; decel_rate_now > $past(decel_rate_now) |->
      decel_rate_now - $past(decel_rate_now) <= 16'h000f; endproperty
   a_slew: assert property (p_slew) else $error("decel rate rose too fast");
   property p_floor; decel_rate_now >= 16'h000f; endproperty
   a_floor: assert property (p_floor) else $error("decel rate under floor");
endmodule
bind dbp_top dbp_top_chk u_chk (.*);
`default_nettype wire

// ==== dbp_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbp_defines.svh"
module dbp_top_tb;
   localparam int TC = 10; // Short tick keeps slow logic quick
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, e;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, h;
   logic [15:0] bus_voltage_mv = 16'h4e20, motor_current_ma = 16'h0, measured_power_w = 16'h0;
   logic brake_resistor_on, drive_shutdown, overvoltage_fault, undervoltage_fault;
   logic power_loop_active;
   logic [15:0] decel_rate_now, accel_rate_now, power_command;
   int err_count = 0, checked = 0, cyc = 0;
   // Settings reset values, offset 0 upward
   logic [31:0] rv [15] = '{`DBP_RST_CTRL, `DBP_RST_ENGAGE, `DBP_RST_DISENG, `DBP_RST_HEATLIM,
      `DBP_RST_COOL, `DBP_RST_OVLIM, `DBP_RST_UVLIM, `DBP_RST_DECV, `DBP_RST_ACCI,
      `DBP_RST_RATE, `DBP_RST_RATE, `DBP_RST_PLIM, `DBP_RST_PLIM, `DBP_RST_KP, `DBP_RST_KI};
   dbp_top #(.TICK_CYCLES(TC)) DUT (.*);
   always #20 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Idle edge first, so calls in a row never collide
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      h = prdata;
      e = pslverr;
      chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(h, exp);
   endtask
   // Bounded wait for the resistor to reach a level
   task automatic wt(input logic v, input int lim);
      int n;
      n = 0;
      while (brake_resistor_on !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, brake_resistor_on}, {31'h0, v});
   endtask
   task automatic summarize();
      if (err_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard; the run needs under a thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         $display("Error at %0t: timeout", $time);
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 15; i++) rc(8'(4 * i), rv[i]);
      rc(8'h5c, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, `DBP_OFF_ACCPWR, 32'h5);
      rc(`DBP_OFF_ACCPWR, 32'h0);
      apb(1'b1, `DBP_OFF_HEATLIM, 32'h14);
      apb(1'b1, `DBP_OFF_COOL, 32'hf);
      bus_voltage_mv <= `DBP_RST_ENGAGE;
      wt(1'b1, 3 * TC);
      bus_voltage_mv <= 16'h9089;
      apb(1'b0, `DBP_OFF_HEAT, 32'h0);
      chk(h, 32'h0);
      repeat (3 * TC - 3) @(posedge pclk);
      rc(`DBP_OFF_HEAT, 32'h3);
      bus_voltage_mv <= `DBP_RST_DISENG;
      wt(1'b0, 2 * TC);
      bus_voltage_mv <= `DBP_RST_ENGAGE;
      wt(1'b1, 3 * TC);
      wt(1'b0, 25 * TC);
      rc(`DBP_OFF_STATUS, 32'h8);
      repeat (3 * TC) @(posedge pclk);
      chk({31'h0, brake_resistor_on}, 32'h0);
      wt(1'b1, 10 * TC);
      apb(1'b1, `DBP_OFF_CTRL, 32'h0);
      wt(1'b0, 3);
      bus_voltage_mv <= 16'h9c41;
      repeat (2) @(posedge pclk);
      chk({30'h0, overvoltage_fault, drive_shutdown}, 32'h3);
      bus_voltage_mv <= 16'h270f;
      repeat (2) @(posedge pclk);
      chk({30'h0, undervoltage_fault, drive_shutdown}, 32'h3);
      apb(1'b1, `DBP_OFF_DECV, 32'h3e8);
      apb(1'b1, `DBP_OFF_ACCI, 32'h3e8);
      bus_voltage_mv <= 16'hfde8;
      motor_current_ma <= 16'hfde8;
      repeat (2 * TC) @(posedge pclk);
      chk({decel_rate_now, accel_rate_now}, 32'h000f000f);
      bus_voltage_mv <= 16'h03e7;
      motor_current_ma <= 16'h0;
      repeat (TC + 1) @(posedge pclk);
      chk({decel_rate_now, accel_rate_now}, 32'h001e001e);
      // Frozen clock enable must hold the slew across two ticks
      clk_en <= 1'b0;
      repeat (2 * TC) @(posedge pclk);
      chk({decel_rate_now, accel_rate_now}, 32'h001e001e);
      clk_en <= 1'b1;
      bus_voltage_mv <= 16'h4e20;
      apb(1'b1, `DBP_OFF_STATUS, 32'h3);
      apb(1'b1, `DBP_OFF_PMAX, 32'h64);
      apb(1'b1, `DBP_OFF_PMIN, 32'h14);
      apb(1'b1, `DBP_OFF_PTGT, 32'h12c);
      apb(1'b1, `DBP_OFF_CTRL, 32'h4);
      repeat (2 * TC) @(posedge pclk);
      chk({drive_shutdown, power_command}, 32'h64);
      apb(1'b1, `DBP_OFF_PTGT, 32'h5);
      repeat (2 * TC) @(posedge pclk);
      chk({power_loop_active, power_command}, 32'h14);
      apb(1'b1, `DBP_OFF_KP, 32'h10000);
      apb(1'b1, `DBP_OFF_KI, 32'h0);
      apb(1'b1, `DBP_OFF_PTGT, 32'h32);
      apb(1'b1, `DBP_OFF_CTRL, 32'h6);
      repeat (3 * TC) @(posedge pclk);
      chk({power_loop_active, power_command}, 32'h10032);
      apb(1'b1, `DBP_OFF_KP, 32'h0);
      apb(1'b1, `DBP_OFF_KI, 32'h10000);
      repeat (3 * TC) @(posedge pclk);
      chk({power_loop_active, power_command}, 32'h10064);
      summarize();
   end
endmodule
`default_nettype wire
